// file: core/uetc_pkg.sv
package uetc_pkg;
    // ---------------------------------------------------------------
    // register map
    // ---------------------------------------------------------------
    localparam logic [7:0] EP0_TX_ADDR = 8'h10;
    localparam logic [7:0] EP1_TX_ADDR = 8'h11;
    localparam logic [7:0] STAT_CTRL_ADDR = 8'h13;
    localparam logic [7:0] REG_RESET = 8'h00;
    // ---------------------------------------------------------------
    // field positions
    // ---------------------------------------------------------------
    localparam int CNT_LSB = 0;
    localparam int CNT_MSB = 3;
    localparam int EP0_INVALID_BIT = 4;
    localparam int EP1_ENABLE_BIT = 4;
    localparam int STALL_BIT = 5;
    localparam int TOGGLE_BIT = 6;
    localparam int ARM_BIT = 7;
    localparam int BUS_ACT_BIT = 0;
    localparam int RESUME_BIT = 1;
    localparam int STATUS_OUT_BIT = 3;
    localparam int OUT_EN_BIT = 4;
    localparam logic [7:0] STAT_CTRL_WMASK = 8'h1b;
    localparam logic [3:0] MAX_COUNT = 4'h8;
    // ---------------------------------------------------------------
    // fifo windows in data memory
    // ---------------------------------------------------------------
    localparam logic [7:0] EP0_FIFO_BASE = 8'h70;
    localparam logic [7:0] EP1_FIFO_BASE = 8'h78;
    localparam logic [7:0] FIFO_SPAN = 8'h08;
    // ---------------------------------------------------------------
    // tokens and replies
    // ---------------------------------------------------------------
    typedef enum logic [1:0] {UETC_TOK_SETUP, UETC_TOK_OUT, UETC_TOK_IN} uetc_tok_t;
    typedef enum logic [2:0] {
        UETC_REP_NONE, UETC_REP_ACK, UETC_REP_NAK, UETC_REP_STALL, UETC_REP_DATA0, UETC_REP_DATA1
    } uetc_reply_t;
endpackage

// file: core/uetc_endpoint_ctrl.sv
`timescale 1ns/10ps
// Functional notes
// R1 - low four tx bits give IN byte count, zero through eight
// R2 - bad DATA in SETUP/OUT phase sets ep0 data-invalid bit 4
// R3 - ep0 stall bit 5 stalls IN/OUT; SETUP clears it
// R4 - tx bit 6 picks DATA0 or DATA1
// R5 - firmware loads fifo, sets toggle, then arms bit 7
// R6 - host ACK of ep0 IN clears arm bit, raises ep0 interrupt
// R7 - SETUP token clears ep0 arm bit
// R8 - ep0 tx, ep1 tx and status/control read zero after reset
// R9 - ep1 transmit only, fifo at 0x78..0x7f
// R10 - ep1 enable bit 4 clear means all ep1 traffic ignored
// R11 - ep1 stall bit 5 stalls IN/OUT until firmware clears it
// R12 - host ACK of ep1 IN clears arm bit, raises ep1 interrupt
// R13 - firmware writes zero to reserved status/control bits
// R14 - any non-idle bus state sets bus-activity bit 0
// R15 - writing 0 to bit 0 clears activity, 1 leaves it
// R16 - firmware should poll and clear activity periodically
// R17 - force-resume bit 1 drives transmitter to K state
// R18 - status-out bit 3: ACK zero-length DATA1, STALL others, no fifo write
// R19 - SETUP on ep0 clears status-out bit 3
// R20 - out-enable bit 4: write fifo and ACK, else NAK
// R21 - out-enable bit 4 cleared after every SETUP or OUT
// R22 - ep0 shares one fifo 0x70..0x77 both directions
// R23 - received-SETUP flag blocks firmware fifo writes
// R24 - unarmed unstalled endpoint answers IN with NAK, state unchanged
module uetc_endpoint_ctrl
    import uetc_pkg::*;
(
    input wire logic ref_clk,
    input wire logic rst,
    input wire logic ioWrite,
    input wire logic ioRead,
    input wire logic [7:0] ioAddr,
    input wire logic [7:0] ioWrData,
    output logic [7:0] ioRdData,
    input wire logic [7:0] memAddr,
    input wire logic memWrite,
    output logic memWriteAllowed,
    input wire logic setupFlag,
    input wire logic tokValid,
    input wire uetc_tok_t tokType,
    input wire logic tokEp,
    input wire logic dataDone,
    input wire logic dataError,
    input wire logic dataPid1,
    input wire logic [3:0] dataLen,
    input wire logic hostAck,
    input wire logic lineDp,
    input wire logic lineDm,
    output uetc_reply_t reply,
    output logic replyValid,
    output logic [3:0] txCount,
    output logic fifoRxWrite,
    output logic ep0Irq,
    output logic ep1Irq,
    output logic driveK
);
    // ---------------------------------------------------------------
    // registers
    // ---------------------------------------------------------------
    logic [7:0] ep0Tx_ff;
    logic [7:0] ep1Tx_ff;
    logic [7:0] statCtrl_ff;
    logic [2:0] dpSync_ff;
    logic [2:0] dmSync_ff;
    logic lineActive_ff;
    logic outPending_ff;
    logic setupPending_ff;
    logic inPendingEp_ff;
    logic inPending_ff;
    logic [7:0] rdData_ff;
    uetc_reply_t reply_ff;
    logic replyValid_ff;
    logic [3:0] txCount_ff;
    logic fifoRxWrite_ff;
    logic ep0Irq_ff;
    logic ep1Irq_ff;

    function automatic logic in_window(input logic [7:0] a, input logic [7:0] base);
        in_window = (a >= base) && (a < base + FIFO_SPAN);
    endfunction

    // ---------------------------------------------------------------
    // token decode
    // ---------------------------------------------------------------
    logic ep1Live;
    logic setupTok;
    logic ep0Out;
    logic ep0In;
    logic ep1In;
    logic ep1Out;
    logic ep0InAck;
    logic ep1InAck;
    logic outDataDone;
    logic statusGood;
    assign ep1Live = ep1Tx_ff[EP1_ENABLE_BIT]; // [R10]
    assign setupTok = tokValid && !tokEp && tokType == UETC_TOK_SETUP;
    assign ep0Out = tokValid && !tokEp && tokType == UETC_TOK_OUT;
    assign ep0In = tokValid && !tokEp && tokType == UETC_TOK_IN;
    assign ep1In = tokValid && tokEp && ep1Live && tokType == UETC_TOK_IN; // [R9]
    assign ep1Out = tokValid && tokEp && ep1Live && tokType == UETC_TOK_OUT;
    assign ep0InAck = hostAck && inPending_ff && !inPendingEp_ff;
    assign ep1InAck = hostAck && inPending_ff && inPendingEp_ff;
    assign outDataDone = dataDone && outPending_ff;
    // zero-length packet counts only the two crc bytes, caller strips them
    assign statusGood = !dataError && dataPid1 && dataLen == 4'h0; // [R18]

    // ---------------------------------------------------------------
    // pending phase tracking
    // ---------------------------------------------------------------
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            outPending_ff <= 1'b0;
            setupPending_ff <= 1'b0;
        end else begin
            if (ep0Out || setupTok) begin
                outPending_ff <= 1'b1;
                setupPending_ff <= setupTok;
            end else if (dataDone) begin
                outPending_ff <= 1'b0;
                setupPending_ff <= 1'b0;
            end
        end
    end

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            inPending_ff <= 1'b0;
            inPendingEp_ff <= 1'b0;
        end else if (tokValid) begin
            inPending_ff <= (ep0In && ep0Tx_ff[ARM_BIT] && !ep0Tx_ff[STALL_BIT])
                || (ep1In && ep1Tx_ff[ARM_BIT] && !ep1Tx_ff[STALL_BIT]);
            inPendingEp_ff <= tokEp;
        end else if (hostAck) begin
            inPending_ff <= 1'b0;
        end
    end

    // ---------------------------------------------------------------
    // reply generation
    // ---------------------------------------------------------------
    logic ep0Stall;
    logic ep1Stall;
    assign ep0Stall = ep0Tx_ff[STALL_BIT];
    assign ep1Stall = ep1Tx_ff[STALL_BIT];

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            reply_ff <= UETC_REP_NONE;
            replyValid_ff <= 1'b0;
            txCount_ff <= REG_RESET[CNT_MSB:CNT_LSB];
        end else begin
            replyValid_ff <= 1'b0;
            reply_ff <= UETC_REP_NONE;
            if (ep0In || ep1In) begin
                replyValid_ff <= 1'b1;
                if (ep0In ? ep0Stall : ep1Stall) begin
                    reply_ff <= UETC_REP_STALL; // [R3] [R11]
                end else if (ep0In ? ep0Tx_ff[ARM_BIT] : ep1Tx_ff[ARM_BIT]) begin
                    reply_ff <= (ep0In ? ep0Tx_ff[TOGGLE_BIT] : ep1Tx_ff[TOGGLE_BIT])
                        ? UETC_REP_DATA1 : UETC_REP_DATA0; // [R4]
                    txCount_ff <= ep0In ? ep0Tx_ff[CNT_MSB:CNT_LSB]
                        : ep1Tx_ff[CNT_MSB:CNT_LSB]; // [R1]
                end else begin
                    reply_ff <= UETC_REP_NAK; // [R24]
                end
            end else if (ep1Out && ep1Stall) begin
                replyValid_ff <= 1'b1;
                reply_ff <= UETC_REP_STALL; // [R11]
            end else if (dataDone && outPending_ff) begin
                // corrupted data gets no handshake at all
                if (!dataError || !setupPending_ff) begin
                    replyValid_ff <= !dataError;
                    if (setupPending_ff) begin
                        reply_ff <= UETC_REP_ACK;
                    end else if (ep0Stall) begin
                        reply_ff <= UETC_REP_STALL; // [R3]
                    end else if (statCtrl_ff[STATUS_OUT_BIT]) begin
                        reply_ff <= statusGood ? UETC_REP_ACK : UETC_REP_STALL; // [R18]
                    end else if (statCtrl_ff[OUT_EN_BIT]) begin
                        reply_ff <= UETC_REP_ACK; // [R20]
                    end else begin
                        reply_ff <= UETC_REP_NAK; // [R20]
                    end
                end
            end
        end
    end

    // shared fifo: setup data always lands, out data only when enabled
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            fifoRxWrite_ff <= 1'b0;
        end else begin
            fifoRxWrite_ff <= outDataDone && (setupPending_ff || (!ep0Stall
                && !statCtrl_ff[STATUS_OUT_BIT] && statCtrl_ff[OUT_EN_BIT])); // [R22] [R18] [R20]
        end
    end

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            ep0Irq_ff <= 1'b0;
            ep1Irq_ff <= 1'b0;
        end else begin
            ep0Irq_ff <= ep0InAck; // [R6]
            ep1Irq_ff <= ep1InAck; // [R12]
        end
    end

    // ---------------------------------------------------------------
    // endpoint 0 transmit register
    // ---------------------------------------------------------------
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            ep0Tx_ff <= REG_RESET; // [R8]
        end else begin
            if (ioWrite && ioAddr == EP0_TX_ADDR) begin
                ep0Tx_ff <= ioWrData;
            end
            if (ep0InAck) begin
                ep0Tx_ff[ARM_BIT] <= 1'b0; // [R6]
            end
            if (outDataDone && dataError) begin
                ep0Tx_ff[EP0_INVALID_BIT] <= 1'b1; // [R2]
            end
            if (setupTok) begin
                ep0Tx_ff[STALL_BIT] <= 1'b0; // [R3]
                ep0Tx_ff[ARM_BIT] <= 1'b0; // [R7]
            end
        end
    end

    // ---------------------------------------------------------------
    // endpoint 1 transmit register
    // ---------------------------------------------------------------
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            ep1Tx_ff <= REG_RESET; // [R8]
        end else begin
            if (ioWrite && ioAddr == EP1_TX_ADDR) begin
                ep1Tx_ff <= ioWrData;
            end
            if (ep1InAck) begin
                ep1Tx_ff[ARM_BIT] <= 1'b0; // [R12]
            end
        end
    end

    // ---------------------------------------------------------------
    // bus activity detection
    // ---------------------------------------------------------------
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            // preset to idle so release of reset is not seen as activity
            dpSync_ff <= '0;
            dmSync_ff <= '1;
            lineActive_ff <= 1'b0;
        end else begin
            dpSync_ff <= {dpSync_ff[1:0], lineDp};
            dmSync_ff <= {dmSync_ff[1:0], lineDm};
            if (dpSync_ff[1] == dpSync_ff[2] && dmSync_ff[1] == dmSync_ff[2]) begin
                lineActive_ff <= dpSync_ff[2] || !dmSync_ff[2]; // [R14]
            end
        end
    end

    // ---------------------------------------------------------------
    // status and control register
    // ---------------------------------------------------------------
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            statCtrl_ff <= REG_RESET; // [R8]
        end else begin
            if (ioWrite && ioAddr == STAT_CTRL_ADDR) begin
                // reserved bits held at zero whatever firmware writes
                statCtrl_ff[RESUME_BIT] <= ioWrData[RESUME_BIT];
                statCtrl_ff[STATUS_OUT_BIT] <= ioWrData[STATUS_OUT_BIT];
                statCtrl_ff[OUT_EN_BIT] <= ioWrData[OUT_EN_BIT];
                if (!ioWrData[BUS_ACT_BIT]) begin
                    statCtrl_ff[BUS_ACT_BIT] <= 1'b0; // [R15]
                end
            end
            if (setupTok) begin
                statCtrl_ff[STATUS_OUT_BIT] <= 1'b0; // [R19]
            end
            if (outDataDone) begin
                statCtrl_ff[OUT_EN_BIT] <= 1'b0; // [R21]
            end
            // set wins over a same-cycle clear
            if (lineActive_ff) begin
                statCtrl_ff[BUS_ACT_BIT] <= 1'b1; // [R14]
            end
        end
    end

    // ---------------------------------------------------------------
    // read port and outputs
    // ---------------------------------------------------------------
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            rdData_ff <= REG_RESET;
        end else if (ioRead) begin
            if (ioAddr == EP0_TX_ADDR) begin
                rdData_ff <= ep0Tx_ff;
            end else if (ioAddr == EP1_TX_ADDR) begin
                rdData_ff <= ep1Tx_ff;
            end else if (ioAddr == STAT_CTRL_ADDR) begin
                rdData_ff <= statCtrl_ff & STAT_CTRL_WMASK;
            end else begin
                rdData_ff <= REG_RESET;
            end
        end
    end

    assign memWriteAllowed = !(setupFlag && (in_window(memAddr, EP0_FIFO_BASE)
        || in_window(memAddr, EP1_FIFO_BASE))); // [R23]
    assign ioRdData = rdData_ff;
    assign reply = reply_ff;
    assign replyValid = replyValid_ff;
    assign txCount = txCount_ff;
    assign fifoRxWrite = fifoRxWrite_ff;
    assign ep0Irq = ep0Irq_ff;
    assign ep1Irq = ep1Irq_ff;
    assign driveK = statCtrl_ff[RESUME_BIT]; // [R17]

    // ---------------------------------------------------------------
    // checks
    // ---------------------------------------------------------------
    a_ack_clears_arm: assert property (@(posedge ref_clk) disable iff (rst) // [R6]
        ep0InAck && !(ioWrite && ioAddr == EP0_TX_ADDR) |=> !ep0Tx_ff[ARM_BIT] && ep0Irq)
        else $error("ep0 ack did not disarm");
    a_ep1_ack_irq: assert property (@(posedge ref_clk) disable iff (rst) // [R12]
        ep1InAck && !(ioWrite && ioAddr == EP1_TX_ADDR) |=> !ep1Tx_ff[ARM_BIT] && ep1Irq)
        else $error("ep1 ack did not disarm");
    a_setup_clears: assert property (@(posedge ref_clk) disable iff (rst) // [R3]
        setupTok |=> !ep0Tx_ff[STALL_BIT] && !ep0Tx_ff[ARM_BIT] && !statCtrl_ff[STATUS_OUT_BIT])
        else $error("setup did not clear");
    a_stall_reply: assert property (@(posedge ref_clk) disable iff (rst) // [R3]
        ep0In && ep0Stall |=> replyValid && reply == UETC_REP_STALL)
        else $error("stall missing");
    a_nak_idle: assert property (@(posedge ref_clk) disable iff (rst) // [R24]
        ep0In && !ep0Stall && !ep0Tx_ff[ARM_BIT] |=> reply == UETC_REP_NAK)
        else $error("nak missing");
    a_toggle_pid: assert property (@(posedge ref_clk) disable iff (rst) // [R4]
        ep1In && !ep1Stall && ep1Tx_ff[ARM_BIT] |=>
        reply == ($past(ep1Tx_ff[TOGGLE_BIT]) ? UETC_REP_DATA1 : UETC_REP_DATA0))
        else $error("wrong data pid");
    a_ep1_ignored: assert property (@(posedge ref_clk) disable iff (rst) // [R10]
        tokValid && tokEp && !ep1Live |=> !replyValid)
        else $error("disabled ep1 answered");
    a_outen_clear: assert property (@(posedge ref_clk) disable iff (rst) // [R21]
        outDataDone |=> !statCtrl_ff[OUT_EN_BIT])
        else $error("out enable stuck");
    a_activity_sets: assert property (@(posedge ref_clk) disable iff (rst) // [R14]
        lineActive_ff |=> statCtrl_ff[BUS_ACT_BIT])
        else $error("activity not flagged");
    a_fifo_guard: assert property (@(posedge ref_clk) disable iff (rst) // [R23]
        setupFlag && in_window(memAddr, EP0_FIFO_BASE) |-> !memWriteAllowed)
        else $error("fifo write not blocked");
    c_ep0_in_ack: cover property (@(posedge ref_clk) ep0InAck);
    c_blocked_write: cover property (@(posedge ref_clk) memWrite && !memWriteAllowed);
    c_status_ack: cover property (@(posedge ref_clk)
        outDataDone && statCtrl_ff[STATUS_OUT_BIT] && statusGood);
    c_ep1_data: cover property (@(posedge ref_clk) ep1In && ep1Tx_ff[ARM_BIT]);
endmodule

// file: tb/uetc_host_model.sv
`timescale 1ns/10ps
module uetc_host_model
    import uetc_pkg::*;
(
    input wire logic ref_clk,
    output logic tokValid,
    output uetc_tok_t tokType,
    output logic tokEp,
    output logic dataDone,
    output logic dataError,
    output logic dataPid1,
    output logic [3:0] dataLen,
    output logic hostAck,
    output logic lineDp,
    output logic lineDm
);
    // ---------------------------------------------------------------
    // host side: tokens, data ends, acks, line levels
    // ---------------------------------------------------------------
    initial begin
        tokValid = 1'b0;
        tokType = UETC_TOK_SETUP;
        tokEp = 1'b0;
        dataDone = 1'b0;
        dataError = 1'b0;
        dataPid1 = 1'b0;
        dataLen = 4'h0;
        hostAck = 1'b0;
        lineDp = 1'b0;
        lineDm = 1'b1;
    end
    task token(input uetc_tok_t t, input logic ep);
        @(negedge ref_clk);
        tokValid = 1'b1;
        tokType = t;
        tokEp = ep;
        @(negedge ref_clk);
        tokValid = 1'b0;
        // endpoint qualifier scrambled once released, so a stale tokEp never helps
        tokEp = ~ep;
    endtask
    task data(input logic err, input logic pid1, input logic [3:0] len);
        @(negedge ref_clk);
        dataDone = 1'b1;
        dataError = err;
        dataPid1 = pid1;
        dataLen = len;
        @(negedge ref_clk);
        dataDone = 1'b0;
        dataError = ~err;
        dataPid1 = ~pid1;
        dataLen = ~len;
    endtask
    task ack();
        @(negedge ref_clk);
        hostAck = 1'b1;
        @(negedge ref_clk);
        hostAck = 1'b0;
    endtask
    task line(input logic dp, input logic dm);
        @(negedge ref_clk);
        lineDp = dp;
        lineDm = dm;
    endtask
endmodule

// file: tb/tb.sv
`timescale 1ns/10ps
module tb import uetc_pkg::*;;
    logic ref_clk = 1'b0;
    logic rst, ioWrite, ioRead, memWrite, setupFlag, memWriteAllowed;
    logic [7:0] ioAddr, ioWrData, ioRdData, memAddr;
    logic tokValid, tokEp, dataDone, dataError, dataPid1, hostAck, lineDp, lineDm;
    logic replyValid, fifoRxWrite, ep0Irq, ep1Irq, driveK;
    logic [3:0] dataLen, txCount, gotCnt;
    uetc_tok_t tokType;
    uetc_reply_t reply, gotRep;
    int err_count = 0;
    int n_checks = 0;
    int nRep, nFifo, nIrq0, nIrq1;

    uetc_endpoint_ctrl uut (.ref_clk(ref_clk), .rst(rst), .ioWrite(ioWrite), .ioRead(ioRead),
        .ioAddr(ioAddr), .ioWrData(ioWrData), .ioRdData(ioRdData), .memAddr(memAddr),
        .memWrite(memWrite), .memWriteAllowed(memWriteAllowed), .setupFlag(setupFlag),
        .tokValid(tokValid), .tokType(tokType), .tokEp(tokEp), .dataDone(dataDone),
        .dataError(dataError), .dataPid1(dataPid1), .dataLen(dataLen), .hostAck(hostAck),
        .lineDp(lineDp), .lineDm(lineDm), .reply(reply), .replyValid(replyValid),
        .txCount(txCount), .fifoRxWrite(fifoRxWrite), .ep0Irq(ep0Irq), .ep1Irq(ep1Irq),
        .driveK(driveK));
    uetc_host_model host (.ref_clk(ref_clk), .tokValid(tokValid), .tokType(tokType),
        .tokEp(tokEp), .dataDone(dataDone), .dataError(dataError), .dataPid1(dataPid1),
        .dataLen(dataLen), .hostAck(hostAck), .lineDp(lineDp), .lineDm(lineDm));

    always #20 ref_clk = ~ref_clk;
    // single-cycle pulses are counted so a doubled pulse is caught too
    always @(posedge ref_clk) begin
        if (replyValid === 1'b1) begin
            nRep++;
            gotRep = reply;
            gotCnt = txCount;
        end
        if (fifoRxWrite === 1'b1) nFifo++;
        if (ep0Irq === 1'b1) nIrq0++;
        if (ep1Irq === 1'b1) nIrq1++;
    end
    // ---------------------------------------------------------------
    // shared tasks
    // ---------------------------------------------------------------
    task end_of_test();
        $display("checks %0d mismatches %0d", n_checks, err_count);
        if (err_count == 0 && n_checks > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask
    task chk(input logic [7:0] got, input logic [7:0] exp);
        n_checks++;
        if (got !== exp) begin
            err_count++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task wr(input logic [7:0] a, input logic [7:0] d);
        @(negedge ref_clk);
        ioWrite = 1'b1;
        ioAddr = a;
        ioWrData = d;
        @(negedge ref_clk);
        ioWrite = 1'b0;
    endtask
    task rdChk(input logic [7:0] a, input logic [7:0] exp);
        @(negedge ref_clk);
        ioRead = 1'b1;
        ioAddr = a;
        @(negedge ref_clk);
        ioRead = 1'b0;
        chk(ioRdData, exp);
    endtask
    task xfer(input uetc_tok_t t, input logic ep, input logic dat, input logic pid1,
              input logic [3:0] len, input logic err, input uetc_reply_t exp);
        nRep = 0;
        nFifo = 0;
        host.token(t, ep);
        if (dat) host.data(err, pid1, len);
        repeat (4) @(negedge ref_clk);
        chk(8'(nRep), (exp == UETC_REP_NONE) ? 8'h00 : 8'h01);
        if (exp != UETC_REP_NONE) chk(8'(gotRep), 8'(exp));
    endtask
    task ackChk(input logic ep);
        nIrq0 = 0;
        nIrq1 = 0;
        host.ack();
        repeat (3) @(negedge ref_clk);
        chk(8'(nIrq0), {7'h00, ~ep});
        chk(8'(nIrq1), {7'h00, ep});
    endtask
    task fillFifo(input logic [7:0] base);
        for (int i = 0; i < 8; i++) begin
            @(negedge ref_clk);
            memAddr = base + 8'(i);
            memWrite = 1'b1;
        end
        @(negedge ref_clk);
        memWrite = 1'b0;
    endtask
    task memChk(input logic [7:0] a, input logic flag, input logic exp);
        @(negedge ref_clk);
        setupFlag = flag;
        memAddr = a;
        #1 chk({7'h00, memWriteAllowed}, {7'h00, exp});
    endtask
    // ---------------------------------------------------------------
    // scenarios
    // ---------------------------------------------------------------
    task s_reset();
        rdChk(EP0_TX_ADDR, REG_RESET);
        rdChk(EP1_TX_ADDR, REG_RESET);
        rdChk(STAT_CTRL_ADDR, REG_RESET);
        rdChk(8'h12, 8'h00);
    endtask
    task s_ep0_in();
        fillFifo(EP0_FIFO_BASE);
        wr(EP0_TX_ADDR, 8'h48);
        wr(EP0_TX_ADDR, 8'hc8);
        xfer(UETC_TOK_IN, 1'b0, 1'b0, 1'b0, 4'h0, 1'b0, UETC_REP_DATA1);
        chk({4'h0, gotCnt}, {4'h0, MAX_COUNT});
        rdChk(EP0_TX_ADDR, 8'hc8);
        ackChk(1'b0);
        rdChk(EP0_TX_ADDR, 8'h48);
        xfer(UETC_TOK_IN, 1'b0, 1'b0, 1'b0, 4'h0, 1'b0, UETC_REP_NAK);
        rdChk(EP0_TX_ADDR, 8'h48);
        wr(EP0_TX_ADDR, 8'h80);
        xfer(UETC_TOK_IN, 1'b0, 1'b0, 1'b0, 4'h0, 1'b0, UETC_REP_DATA0);
        chk({4'h0, gotCnt}, 8'h00);
        ackChk(1'b0);
    endtask
    task s_ep0_setup();
        wr(EP0_TX_ADDR, 8'ha3);
        wr(STAT_CTRL_ADDR, 8'h18);
        xfer(UETC_TOK_IN, 1'b0, 1'b0, 1'b0, 4'h0, 1'b0, UETC_REP_STALL);
        xfer(UETC_TOK_SETUP, 1'b0, 1'b1, 1'b0, 4'h8, 1'b1, UETC_REP_NONE);
        chk(8'(nFifo), 8'h01);
        rdChk(EP0_TX_ADDR, 8'h13);
        rdChk(STAT_CTRL_ADDR, 8'h00);
        wr(EP0_TX_ADDR, 8'h20);
        xfer(UETC_TOK_OUT, 1'b0, 1'b1, 1'b0, 4'h4, 1'b0, UETC_REP_STALL);
        chk(8'(nFifo), 8'h00);
        wr(EP0_TX_ADDR, 8'h00);
    endtask
    task s_ep0_out();
        wr(STAT_CTRL_ADDR, 8'h10);
        xfer(UETC_TOK_OUT, 1'b0, 1'b1, 1'b0, 4'h4, 1'b0, UETC_REP_ACK);
        chk(8'(nFifo), 8'h01);
        rdChk(STAT_CTRL_ADDR, 8'h00);
        xfer(UETC_TOK_OUT, 1'b0, 1'b1, 1'b1, 4'h4, 1'b0, UETC_REP_NAK);
        chk(8'(nFifo), 8'h00);
    endtask
    task s_status();
        wr(STAT_CTRL_ADDR, 8'h18);
        xfer(UETC_TOK_OUT, 1'b0, 1'b1, 1'b1, 4'h0, 1'b0, UETC_REP_ACK);
        chk(8'(nFifo), 8'h00);
        rdChk(STAT_CTRL_ADDR, 8'h08);
        xfer(UETC_TOK_OUT, 1'b0, 1'b1, 1'b0, 4'h0, 1'b0, UETC_REP_STALL);
        xfer(UETC_TOK_OUT, 1'b0, 1'b1, 1'b1, 4'h2, 1'b0, UETC_REP_STALL);
        chk(8'(nFifo), 8'h00);
        xfer(UETC_TOK_SETUP, 1'b0, 1'b1, 1'b0, 4'h8, 1'b0, UETC_REP_ACK);
        rdChk(STAT_CTRL_ADDR, 8'h00);
    endtask
    task s_ep1();
        fillFifo(EP1_FIFO_BASE);
        wr(EP1_TX_ADDR, 8'h85);
        xfer(UETC_TOK_IN, 1'b1, 1'b0, 1'b0, 4'h0, 1'b0, UETC_REP_NONE);
        rdChk(EP1_TX_ADDR, 8'h85);
        wr(EP1_TX_ADDR, 8'hd5);
        xfer(UETC_TOK_IN, 1'b1, 1'b0, 1'b0, 4'h0, 1'b0, UETC_REP_DATA1);
        chk({4'h0, gotCnt}, 8'h05);
        ackChk(1'b1);
        rdChk(EP1_TX_ADDR, 8'h55);
        wr(EP1_TX_ADDR, 8'h30);
        xfer(UETC_TOK_IN, 1'b1, 1'b0, 1'b0, 4'h0, 1'b0, UETC_REP_STALL);
        xfer(UETC_TOK_OUT, 1'b1, 1'b0, 1'b0, 4'h0, 1'b0, UETC_REP_STALL);
        rdChk(EP1_TX_ADDR, 8'h30);
        wr(EP1_TX_ADDR, 8'h10);
        xfer(UETC_TOK_IN, 1'b1, 1'b0, 1'b0, 4'h0, 1'b0, UETC_REP_NAK);
    endtask
    task s_bus();
        wr(STAT_CTRL_ADDR, 8'h02);
        chk({7'h00, driveK}, 8'h01);
        rdChk(STAT_CTRL_ADDR, 8'h02);
        wr(STAT_CTRL_ADDR, 8'h00);
        chk({7'h00, driveK}, 8'h00);
        rdChk(STAT_CTRL_ADDR, 8'h00);
        host.line(1'b0, 1'b0);
        repeat (2) @(negedge ref_clk);
        host.line(1'b0, 1'b1);
        repeat (8) @(negedge ref_clk);
        rdChk(STAT_CTRL_ADDR, 8'h01);
        wr(STAT_CTRL_ADDR, 8'h01);
        rdChk(STAT_CTRL_ADDR, 8'h01);
        wr(STAT_CTRL_ADDR, 8'h00);
        rdChk(STAT_CTRL_ADDR, 8'h00);
    endtask
    task s_guard();
        memChk(EP0_FIFO_BASE, 1'b1, 1'b0);
        memChk(EP1_FIFO_BASE + 8'h07, 1'b1, 1'b0);
        memChk(8'h6f, 1'b1, 1'b1);
        memChk(8'h80, 1'b1, 1'b1);
        memChk(EP0_FIFO_BASE, 1'b0, 1'b1);
    endtask

    initial begin
        rst = 1'b1;
        ioWrite = 1'b0;
        ioRead = 1'b0;
        ioAddr = 8'h00;
        ioWrData = 8'h00;
        memAddr = 8'h00;
        memWrite = 1'b0;
        setupFlag = 1'b0;
        repeat (16) @(negedge ref_clk);
        rst = 1'b0;
        s_reset();
        s_ep0_in();
        s_ep0_setup();
        s_ep0_out();
        s_status();
        s_ep1();
        s_bus();
        s_guard();
        end_of_test();
    end
    // whole run is well under a thousand cycles
    initial begin
        repeat (20000) @(posedge ref_clk);
        err_count++;
        end_of_test();
    end
endmodule
